// [key_led_matrix_scanner_regs.svh]
// constants for the operator panel key and lamp matrix scanner
`ifndef KEY_LED_MATRIX_SCANNER_REGS_SVH
`define KEY_LED_MATRIX_SCANNER_REGS_SVH

// clock and scan timing, times in nanoseconds
`define CLK_PERIOD_NS        8
`define KEY_SCAN_PERIOD_NS   11680000
`define LAMP_ON_NS           1280000
`define LAMP_PERIOD_NS       5840000

// matrix geometry
`define KEY_ROWS             8
`define KEY_COLS             8
`define KEY_POINTS           64
`define LAMP_ROWS            4
`define LAMP_COLS            4
`define LAMP_POINTS          16
`define KEY_ROW_W            3
`define LAMP_ROW_W           2
`define CNT_W                20

// register bus
`define ADDR_W               8
`define DATA_W               32
`define REG_CTRL             8'h00
`define REG_STATUS           8'h04
`define REG_MASK             8'h08
`define REG_KEY_LO           8'h0C
`define REG_KEY_HI           8'h10
`define REG_LAMP             8'h14
`define REG_INDICATOR        8'h18

// control fields and reset values
`define CTRL_SCAN_EN_BIT     0
`define CTRL_LAMP_EN_BIT     1
`define CTRL_W               2
`define CTRL_RESET           2'h3
`define MASK_RESET           8'h00
`define LAMP_RESET           32'h0000_0000

// status and mask layout
`define EVT_W                8
`define ST_KEY_CHANGE_BIT    0
`define ST_FUSE1_BIT         1
`define ST_SECOND_FUSE_LAMP_BIT         2
`define ST_ESTOP_BIT         3
`define ST_LINK_LSB          4
`define LINK_COUNT           4

`endif

// [key_led_matrix_scanner_pkg.sv]
// types shared by the key and lamp matrix scanner
`include "key_led_matrix_scanner_regs.svh"

package key_led_matrix_scanner_pkg;

   typedef enum logic [0:0] {
      LAMP_SLOT  = 1'b0,
      LAMP_BLANK = 1'b1
   } lamp_phase_type;

   typedef logic [`CNT_W-1:0]      count_type;
   typedef logic [`KEY_ROW_W-1:0]  key_row_type;
   typedef logic [`LAMP_ROW_W-1:0] lamp_row_type;

endpackage

// [key_led_matrix_scanner.sv]
// key matrix scanner, lamp matrix driver, alarm indicators and register slave
`include "key_led_matrix_scanner_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_sys_i,
   input  wire logic             resetn_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta_reg, sync_reg;

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;
endmodule

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1 - read 64 keys as eight row commons crossed with eight column inputs
// R2 - drive commons in turn, capture columns only from the row driven low
// R3 - full common changeover cycle repeats every 11.68 ms
// R4 - key counts as pressed only if held on across a whole ladder cycle
// R5 - drive 32 lamps as two independent four by four matrices
// R6 - lamp lit only while its common is high and its column is active
// R7 - step four lamp commons in order, 1.28 ms each, every 5.84 ms
// R8 - both fuse lamps lit normally, dark once their fuse has blown
// R9 - emergency stop lamp dark normally, lit while stop input present
// R10 - each link alarm lamp dark normally, lit on its link error
// R11 - at most one key common low, others held high in each slot
// R12 - keep 64-bit key image from row captures, publish once per ladder cycle
module key_led_matrix_scanner
   import key_led_matrix_scanner_pkg::*;
#(
   parameter count_type KEY_SLOT_CYCLES =
      `CNT_W'(`KEY_SCAN_PERIOD_NS / (`CLK_PERIOD_NS * `KEY_ROWS)),
   parameter count_type LAMP_ON_CYCLES =
      `CNT_W'(`LAMP_ON_NS / `CLK_PERIOD_NS),
   parameter count_type LAMP_BLANK_CYCLES =
      `CNT_W'((`LAMP_PERIOD_NS - `LAMP_ROWS * `LAMP_ON_NS) / `CLK_PERIOD_NS)
) (
   // clock and reset
   input  wire logic                    clk_sys_i,
   input  wire logic                    resetn_i,
   // register port
   input  wire logic [`ADDR_W-1:0]      reg_addr_i,
   input  wire logic [`DATA_W-1:0]      reg_wdata_i,
   input  wire logic                    reg_write_i,
   input  wire logic                    reg_read_i,
   output logic      [`DATA_W-1:0]      reg_rdata_o,
   // key matrix pins
   output logic      [`KEY_ROWS-1:0]    key_row_common_n_o,
   input  wire logic [`KEY_COLS-1:0]    key_column_in_n_i,
   // lamp matrix pins
   output logic      [`LAMP_ROWS-1:0]   lamp_row_common_a_o,
   output logic      [`LAMP_COLS-1:0]   lamp_column_drive_a_n_o,
   output logic      [`LAMP_ROWS-1:0]   lamp_row_common_b_o,
   output logic      [`LAMP_COLS-1:0]   lamp_column_drive_b_n_o,
   // ladder side
   input  wire logic                    ladder_tick_i,
   output logic      [`KEY_POINTS-1:0]  key_image_o,
   output logic                         key_image_valid_o,
   // indicator sources and lamps
   input  wire logic [1:0]              fuse_blown_i,
   input  wire logic                    emergency_stop_i,
   input  wire logic [`LINK_COUNT-1:0]  link_error_i,
   output logic                         fuse_lamp_o,
   output logic                         second_fuse_lamp_o,
   output logic                         emergency_stop_lamp_o,
   output logic                         link_alarm_lamp_1_o,
   output logic                         link_alarm_lamp_2_o,
   output logic                         link_alarm_lamp_3_o,
   output logic                         link_alarm_lamp_4_o,
   // interrupt
   output logic                         irq_o
);

   /////////////////////////////////////////////////////////////////////////////
   // synchronisers for pin inputs
   logic [`KEY_COLS-1:0] column_sync;
   logic [2:0]           fault_sync;

   sync2 #(.WIDTH(`KEY_COLS)) column_sync_inst (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .async_i   (key_column_in_n_i),
      .sync_o    (column_sync)
   );

   sync2 #(.WIDTH(3)) fault_sync_inst (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .async_i   ({emergency_stop_i, fuse_blown_i}),
      .sync_o    (fault_sync)
   );

   /////////////////////////////////////////////////////////////////////////////
   // control registers
   logic [`CTRL_W-1:0]  ctrl_reg, ctrl_next;
   logic [`EVT_W-1:0]   status_reg, status_next;
   logic [`EVT_W-1:0]   mask_reg, mask_next;
   logic [`DATA_W-1:0]  lamp_reg, lamp_next;
   logic [`DATA_W-1:0]  rdata_reg, rdata_next;
   logic [`EVT_W-1:0]   events, clear_bits;

   /////////////////////////////////////////////////////////////////////////////
   // key scan: row counter and capture
   key_row_type             key_row_reg, key_row_next;
   count_type               key_cnt_reg, key_cnt_next;
   logic [`KEY_ROWS-1:0]    key_drive_n_reg, key_drive_n_next;
   logic [`KEY_POINTS-1:0]  raw_reg, raw_next;
   logic [`KEY_POINTS-1:0]  held_reg, held_next;
   logic [`KEY_POINTS-1:0]  image_reg, image_next;
   logic                    image_valid_reg, image_valid_next;
   logic                    key_change_evt, capture, scan_en;
   assign scan_en = ctrl_reg[`CTRL_SCAN_EN_BIT];
   // sample at slot end, long after the common switched and the synchroniser settled
   assign capture = scan_en && (key_cnt_reg == KEY_SLOT_CYCLES - `CNT_W'(1));

   always_comb begin
      key_row_next     = key_row_reg;
      key_cnt_next     = key_cnt_reg;
      key_drive_n_next = '1;
      raw_next         = raw_reg;
      held_next        = held_reg;
      image_next       = image_reg;
      image_valid_next = 1'b0;
      key_change_evt   = 1'b0;
      if (!scan_en) begin
         key_row_next = '0;
         key_cnt_next = '0;
      end else if (capture) begin
         key_cnt_next = '0;
         key_row_next = key_row_reg + key_row_type'(1); // R3
      end else begin
         key_cnt_next = key_cnt_reg + count_type'(1);
      end
      if (scan_en) begin
         key_drive_n_next = ~(`KEY_ROWS'(1) << key_row_reg); // R11
      end
      if (capture) begin
         raw_next[key_row_reg*`KEY_COLS +: `KEY_COLS] = ~column_sync; // R1 R2
         held_next[key_row_reg*`KEY_COLS +: `KEY_COLS] =
            held_reg[key_row_reg*`KEY_COLS +: `KEY_COLS] & ~column_sync; // R4
      end
      if (ladder_tick_i) begin
         image_next       = held_next; // R4 R12
         held_next        = raw_next;
         image_valid_next = 1'b1; // R12
         key_change_evt   = (image_next != image_reg);
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         key_row_reg     <= '0;
         key_cnt_reg     <= '0;
         key_drive_n_reg <= '1;
         raw_reg         <= '0;
         held_reg        <= '0;
         image_reg       <= '0;
         image_valid_reg <= 1'b0;
      end else begin
         key_row_reg     <= key_row_next;
         key_cnt_reg     <= key_cnt_next;
         key_drive_n_reg <= key_drive_n_next;
         raw_reg         <= raw_next;
         held_reg        <= held_next;
         image_reg       <= image_next;
         image_valid_reg <= image_valid_next;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // lamp scan: four lit slots then one blank gap make up the period
   lamp_phase_type          lamp_phase_reg, lamp_phase_next;
   lamp_row_type            lamp_row_reg, lamp_row_next;
   count_type               lamp_cnt_reg, lamp_cnt_next;
   logic [`LAMP_ROWS-1:0]   common_a_reg, common_a_next;
   logic [`LAMP_ROWS-1:0]   common_b_reg, common_b_next;
   logic [`LAMP_COLS-1:0]   column_a_n_reg, column_a_n_next;
   logic [`LAMP_COLS-1:0]   column_b_n_reg, column_b_n_next;
   logic                    lamp_en;
   assign lamp_en = ctrl_reg[`CTRL_LAMP_EN_BIT];

   always_comb begin
      lamp_phase_next = lamp_phase_reg;
      lamp_row_next   = lamp_row_reg;
      lamp_cnt_next   = lamp_cnt_reg + count_type'(1);
      common_a_next   = '0;
      common_b_next   = '0;
      column_a_n_next = '1;
      column_b_n_next = '1;
      if (!lamp_en) begin
         lamp_phase_next = LAMP_SLOT;
         lamp_row_next   = '0;
         lamp_cnt_next   = '0;
      end else begin
         case (lamp_phase_reg)
            LAMP_SLOT: begin
               if (lamp_cnt_reg == LAMP_ON_CYCLES - `CNT_W'(1)) begin
                  lamp_cnt_next = '0;
                  if (lamp_row_reg == lamp_row_type'(`LAMP_ROWS - 1)) begin
                     lamp_phase_next = LAMP_BLANK; // R7
                     lamp_row_next   = '0;
                  end else begin
                     lamp_row_next = lamp_row_reg + lamp_row_type'(1); // R7
                  end
               end
            end
            LAMP_BLANK: begin
               if (lamp_cnt_reg == LAMP_BLANK_CYCLES - `CNT_W'(1)) begin
                  lamp_cnt_next   = '0;
                  lamp_phase_next = LAMP_SLOT;
               end
            end
            default: begin
               lamp_phase_next = LAMP_SLOT;
               lamp_row_next   = '0;
               lamp_cnt_next   = '0;
            end
         endcase
      end
      if (lamp_en && lamp_phase_reg == LAMP_SLOT) begin
         // both matrices share timing but take columns from their own image
         common_a_next   = `LAMP_ROWS'(1) << lamp_row_reg; // R5 R6
         common_b_next   = `LAMP_ROWS'(1) << lamp_row_reg; // R5 R6
         column_a_n_next = ~lamp_reg[lamp_row_reg*`LAMP_COLS +: `LAMP_COLS]; // R6
         column_b_n_next =
            ~lamp_reg[`LAMP_POINTS + lamp_row_reg*`LAMP_COLS +: `LAMP_COLS]; // R5 R6
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lamp_phase_reg <= LAMP_SLOT;
         lamp_row_reg   <= '0;
         lamp_cnt_reg   <= '0;
         common_a_reg   <= '0;
         common_b_reg   <= '0;
         column_a_n_reg <= '1;
         column_b_n_reg <= '1;
      end else begin
         lamp_phase_reg <= lamp_phase_next;
         lamp_row_reg   <= lamp_row_next;
         lamp_cnt_reg   <= lamp_cnt_next;
         common_a_reg   <= common_a_next;
         common_b_reg   <= common_b_next;
         column_a_n_reg <= column_a_n_next;
         column_b_n_reg <= column_b_n_next;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // indicator lamps and fault edge detection
   logic [2:0]              fault_prev_reg;
   logic [`LINK_COUNT-1:0]  link_prev_reg;
   logic [`LINK_COUNT-1:0]  link_lamp_reg;
   logic [2:0]              fault_lamp_reg, fault_lamp_next;

   always_comb begin
      fault_lamp_next[0] = ~fault_sync[0]; // R8
      fault_lamp_next[1] = ~fault_sync[1]; // R8
      fault_lamp_next[2] = fault_sync[2]; // R9
      events = '0;
      events[`ST_KEY_CHANGE_BIT] = key_change_evt;
      events[`ST_FUSE1_BIT]      = fault_sync[0] & ~fault_prev_reg[0];
      events[`ST_SECOND_FUSE_LAMP_BIT]      = fault_sync[1] & ~fault_prev_reg[1];
      events[`ST_ESTOP_BIT]      = fault_sync[2] & ~fault_prev_reg[2];
      events[`ST_LINK_LSB +: `LINK_COUNT] = link_error_i & ~link_prev_reg;
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fault_prev_reg <= '0;
         link_prev_reg  <= '0;
         link_lamp_reg  <= '0;
         fault_lamp_reg <= 3'h3;
      end else begin
         fault_prev_reg <= fault_sync;
         link_prev_reg  <= link_error_i;
         link_lamp_reg  <= link_error_i; // R10
         fault_lamp_reg <= fault_lamp_next;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // register slave: read data stand only in the cycle after the strobe
   always_comb begin
      ctrl_next  = ctrl_reg;
      mask_next  = mask_reg;
      lamp_next  = lamp_reg;
      clear_bits = '0;
      rdata_next = '0;
      if (reg_write_i) begin
         case (reg_addr_i)
            `REG_CTRL:   ctrl_next  = reg_wdata_i[`CTRL_W-1:0];
            `REG_STATUS: clear_bits = reg_wdata_i[`EVT_W-1:0];
            `REG_MASK:   mask_next  = reg_wdata_i[`EVT_W-1:0];
            `REG_LAMP:   lamp_next  = reg_wdata_i;
            default:     ctrl_next  = ctrl_reg;
         endcase
      end
      // a new event in the clearing cycle survives the clear
      status_next = (status_reg & ~clear_bits) | events;
      if (reg_read_i) begin
         case (reg_addr_i)
            `REG_CTRL:      rdata_next = {{(`DATA_W-`CTRL_W){1'b0}}, ctrl_reg};
            `REG_STATUS:    rdata_next = {{(`DATA_W-`EVT_W){1'b0}}, status_reg};
            `REG_MASK:      rdata_next = {{(`DATA_W-`EVT_W){1'b0}}, mask_reg};
            `REG_KEY_LO:    rdata_next = image_reg[`DATA_W-1:0];
            `REG_KEY_HI:    rdata_next = image_reg[`KEY_POINTS-1:`DATA_W];
            `REG_LAMP:      rdata_next = lamp_reg;
            `REG_INDICATOR: rdata_next = {{(`DATA_W-7){1'b0}},
                                          link_lamp_reg, fault_lamp_reg};
            default:        rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_reg   <= `CTRL_RESET;
         status_reg <= '0;
         mask_reg   <= `MASK_RESET;
         lamp_reg   <= `LAMP_RESET;
         rdata_reg  <= '0;
      end else begin
         ctrl_reg   <= ctrl_next;
         status_reg <= status_next;
         mask_reg   <= mask_next;
         lamp_reg   <= lamp_next;
         rdata_reg  <= rdata_next;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata_o             = rdata_reg;
   assign irq_o                   = |(status_reg & mask_reg);
   assign key_row_common_n_o      = key_drive_n_reg;
   assign lamp_row_common_a_o     = common_a_reg;
   assign lamp_column_drive_a_n_o = column_a_n_reg;
   assign lamp_row_common_b_o     = common_b_reg;
   assign lamp_column_drive_b_n_o = column_b_n_reg;
   assign key_image_o             = image_reg;
   assign key_image_valid_o       = image_valid_reg;
   assign fuse_lamp_o             = fault_lamp_reg[0];
   assign second_fuse_lamp_o      = fault_lamp_reg[1];
   assign emergency_stop_lamp_o   = fault_lamp_reg[2];
   assign link_alarm_lamp_1_o     = link_lamp_reg[0];
   assign link_alarm_lamp_2_o     = link_lamp_reg[1];
   assign link_alarm_lamp_3_o     = link_lamp_reg[2];
   assign link_alarm_lamp_4_o     = link_lamp_reg[3];

endmodule

// [key_led_matrix_scanner_assertions.sv]
// port assertions for the key and lamp matrix scanner
`include "key_led_matrix_scanner_regs.svh"
module key_led_matrix_scanner_assertions
   import key_led_matrix_scanner_pkg::*;
#(
   parameter count_type KEY_SLOT_CYCLES = 20'h10,
   parameter count_type LAMP_ON_CYCLES  = 20'h8
) (
   // clock and reset
   input wire logic                   clk_sys_i,
   input wire logic                   resetn_i,
   // matrix pins
   input wire logic [`KEY_ROWS-1:0]   key_row_common_n_o,
   input wire logic [`LAMP_ROWS-1:0]  lamp_row_common_a_o,
   input wire logic [`LAMP_ROWS-1:0]  lamp_row_common_b_o,
   // ladder side
   input wire logic                   ladder_tick_i,
   input wire logic [`KEY_POINTS-1:0] key_image_o,
   input wire logic                   key_image_valid_o,
   // indicators
   input wire logic [1:0]             fuse_blown_i,
   input wire logic                   emergency_stop_i,
   input wire logic [`LINK_COUNT-1:0] link_error_i,
   input wire logic                   fuse_lamp_o,
   input wire logic                   second_fuse_lamp_o,
   input wire logic                   emergency_stop_lamp_o,
   input wire logic                   link_alarm_lamp_1_o,
   input wire logic                   link_alarm_lamp_2_o,
   input wire logic                   link_alarm_lamp_3_o,
   input wire logic                   link_alarm_lamp_4_o
);
   logic [7:0] row_prev_reg, row_prev_next;
   logic [3:0] lamp_prev_reg, lamp_prev_next;
   count_type  row_age_reg, row_age_next;
   count_type  lamp_age_reg, lamp_age_next;
   logic       row_step;
   logic       lamp_step;

   ////////////////////////////////////////////////////////////////////////////
   // ages restart on each change, so a short or long slot shows at the change
   always_comb begin
      row_prev_next  = key_row_common_n_o;
      lamp_prev_next = lamp_row_common_a_o;
      row_step = (key_row_common_n_o != row_prev_reg) && (row_prev_reg != 8'hFF)
                 && (key_row_common_n_o != 8'hFF);
      lamp_step = (lamp_row_common_a_o != lamp_prev_reg) && (lamp_prev_reg != 4'h0);
      row_age_next  = (key_row_common_n_o != row_prev_reg) ? 20'h1 : row_age_reg + 20'h1;
      lamp_age_next = (lamp_row_common_a_o != lamp_prev_reg) ? 20'h1 : lamp_age_reg + 20'h1;
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         row_prev_reg  <= 8'hFF;
         lamp_prev_reg <= 4'h0;
         row_age_reg   <= 20'h0;
         lamp_age_reg  <= 20'h0;
      end else begin
         row_prev_reg  <= row_prev_next;
         lamp_prev_reg <= lamp_prev_next;
         row_age_reg   <= row_age_next;
         lamp_age_reg  <= lamp_age_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking dcb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   sequence tick_s;
      ladder_tick_i;
   endsequence
   sequence valid_pulse_s;
      key_image_valid_o ##1 !key_image_valid_o;
   endsequence

   chk_one_row_low: assert property ($countones(~key_row_common_n_o) <= 1)
      else $error("more than one key common low");
   chk_row_slot_len: assert property (row_step |-> row_age_reg == KEY_SLOT_CYCLES)
      else $error("key row slot length wrong");
   chk_row_order: assert property (row_step |->
      key_row_common_n_o == {row_prev_reg[6:0], row_prev_reg[7]})
      else $error("key rows out of order");
   chk_lamp_one_hot: assert property ($onehot0(lamp_row_common_a_o)
      && $onehot0(lamp_row_common_b_o)) else $error("two lamp commons high");
   chk_lamp_slot_len: assert property (lamp_step |-> lamp_age_reg == LAMP_ON_CYCLES
      && lamp_row_common_a_o == {lamp_prev_reg[2:0], 1'b0}) else $error("lamp slot wrong");
   chk_valid_after_tick: assert property (tick_s |=> valid_pulse_s)
      else $error("image valid not after tick");
   chk_image_on_valid: assert property ($changed(key_image_o) |-> key_image_valid_o)
      else $error("key image changed off tick");
   chk_fuse_lamps: assert property ($stable(fuse_blown_i)[*3] |->
      {second_fuse_lamp_o, fuse_lamp_o} == ~fuse_blown_i) else $error("fuse lamp wrong");
   chk_estop_lamp: assert property ($stable(emergency_stop_i)[*3] |->
      emergency_stop_lamp_o == emergency_stop_i) else $error("stop lamp wrong");
   chk_link_lamps: assert property ({link_alarm_lamp_4_o, link_alarm_lamp_3_o,
      link_alarm_lamp_2_o, link_alarm_lamp_1_o} == $past(link_error_i))
      else $error("link lamp wrong");
endmodule

bind key_led_matrix_scanner key_led_matrix_scanner_assertions #(
   .KEY_SLOT_CYCLES(KEY_SLOT_CYCLES),
   .LAMP_ON_CYCLES (LAMP_ON_CYCLES)
) u_key_led_matrix_scanner_assertions (
   .clk_sys_i, .resetn_i, .key_row_common_n_o, .lamp_row_common_a_o,
   .lamp_row_common_b_o, .ladder_tick_i, .key_image_o, .key_image_valid_o,
   .fuse_blown_i, .emergency_stop_i, .link_error_i, .fuse_lamp_o, .second_fuse_lamp_o,
   .emergency_stop_lamp_o, .link_alarm_lamp_1_o, .link_alarm_lamp_2_o,
   .link_alarm_lamp_3_o, .link_alarm_lamp_4_o
);

// [key_panel_model.sv]
// passive key switch matrix with diodes and the two lamp matrices
module key_panel_model (
   // key side
   input  wire logic [7:0]  key_row_common_n_i,
   input  wire logic [63:0] pressed_i,
   output logic      [7:0]  key_column_in_n_o,
   // lamp side
   input  wire logic [3:0]  common_a_i,
   input  wire logic [3:0]  column_a_n_i,
   input  wire logic [3:0]  common_b_i,
   input  wire logic [3:0]  column_b_n_i,
   output logic      [31:0] lit_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // diodes stop sneak paths, so only a low common can pull a column down
   always_comb begin
      key_column_in_n_o = 8'hFF;
      lit_o = 32'h0;
      for (int r = 0; r < 8; r++) begin
         for (int c = 0; c < 8; c++) begin
            if (!key_row_common_n_i[r] && pressed_i[r*8+c]) key_column_in_n_o[c] = 1'b0;
         end
      end
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < 4; c++) begin
            lit_o[r*4+c]    = common_a_i[r] & ~column_a_n_i[c];
            lit_o[16+r*4+c] = common_b_i[r] & ~column_b_n_i[c];
         end
      end
   end
endmodule

// [tb.sv]
// self-checking bench for the key and lamp matrix scanner
`include "key_led_matrix_scanner_regs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LADDER = 300;
   logic        clk_sys_i = 1'b0;
   logic        resetn_i = 1'b0;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic        reg_write_i = 1'b0;
   logic        reg_read_i = 1'b0;
   logic [31:0] reg_rdata_o, lit;
   logic [7:0]  rows_n, cols_n;
   logic [3:0]  ca, cna, cb, cnb, al;
   logic [63:0] pressed = 64'h0;
   logic [63:0] image;
   logic        valid, irq, fl, fl2, el;
   logic        tick = 1'b0;
   logic [1:0]  fuse = 2'h0;
   logic        estop = 1'b0;
   logic [3:0]  link = 4'h0;
   logic [31:0] seen_lit;
   int          n_errors = 0;
   int          total_checks = 0;
   int          cycles = 0;
   int          tcnt = 0;
   int          on_cnt;

   key_led_matrix_scanner #(.KEY_SLOT_CYCLES(20'h10), .LAMP_ON_CYCLES(20'h8),
      .LAMP_BLANK_CYCLES(20'h4)) u_key_led_matrix_scanner (
      .clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_write_i, .reg_read_i,
      .reg_rdata_o, .key_row_common_n_o(rows_n), .key_column_in_n_i(cols_n),
      .lamp_row_common_a_o(ca), .lamp_column_drive_a_n_o(cna), .lamp_row_common_b_o(cb),
      .lamp_column_drive_b_n_o(cnb), .ladder_tick_i(tick), .key_image_o(image),
      .key_image_valid_o(valid), .fuse_blown_i(fuse), .emergency_stop_i(estop),
      .link_error_i(link), .fuse_lamp_o(fl), .second_fuse_lamp_o(fl2),
      .emergency_stop_lamp_o(el), .link_alarm_lamp_1_o(al[0]), .link_alarm_lamp_2_o(al[1]),
      .link_alarm_lamp_3_o(al[2]), .link_alarm_lamp_4_o(al[3]), .irq_o(irq));

   key_panel_model u_key_panel_model (.key_row_common_n_i(rows_n), .pressed_i(pressed),
      .key_column_in_n_o(cols_n), .common_a_i(ca), .column_a_n_i(cna), .common_b_i(cb),
      .column_b_n_i(cnb), .lit_o(lit));

   always #4 clk_sys_i = ~clk_sys_i;

   ////////////////////////////////////////////////////////////////////////////
   // ladder ticks and the run ceiling share one counting process
   always @(posedge clk_sys_i) begin
      cycles++;
      tcnt <= (tcnt == LADDER - 1) ? 0 : tcnt + 1;
      tick <= (tcnt == LADDER - 1);
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_write_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_write_i <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_read_i <= 1'b1;
      @(posedge clk_sys_i);
      reg_read_i <= 1'b0;
      #1;
      check(reg_rdata_o, exp);
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      cyc(1);
      check({rows_n, fl2, fl, el, al}, 15'h7FE0);
      @(posedge clk_sys_i) resetn_i <= 1'b1;
      rdc(`REG_CTRL, 32'h3);
      rdc(`REG_MASK, 32'h0);
      rdc(`REG_LAMP, 32'h0);
      rdc(`REG_STATUS, 32'h0);
      rdc(8'h1C, 32'h0);
      rdc(`REG_INDICATOR, 32'h3);
      @(posedge clk_sys_i) pressed <= 64'h8000_0020_0000_0001;
      cyc(3 * LADDER);
      check(image, 64'h8000_0020_0000_0001);
      rdc(`REG_KEY_LO, 32'h1);
      wr(`REG_KEY_LO, 32'h0);
      rdc(`REG_KEY_LO, 32'h1);
      rdc(`REG_KEY_HI, 32'h8000_0020);
      rdc(`REG_STATUS, 32'h1);
      check(irq, 1'b0);
      wr(`REG_MASK, 32'h1);
      cyc(2);
      check(irq, 1'b1);
      wr(`REG_STATUS, 32'h1);
      cyc(2);
      check(irq, 1'b0);
      // a press that starts at a tick and ends within one ladder interval is never recognised
      @(posedge clk_sys_i iff tick);
      pressed <= 64'h8000_0020_0000_0201;
      #1 check(valid, 1'b1);
      cyc(40);
      @(posedge clk_sys_i) pressed <= 64'h8000_0020_0000_0001;
      cyc(3 * LADDER);
      check(image, 64'h8000_0020_0000_0001);
      wr(`REG_LAMP, 32'h8421_0009);
      cyc(4);
      seen_lit = 32'h0;
      on_cnt = 0;
      repeat (72) begin
         cyc(1);
         seen_lit |= lit;
         on_cnt += int'(lit[0]);
      end
      check(seen_lit, 32'h8421_0009);
      check(on_cnt, 16);
      @(posedge clk_sys_i);
      fuse <= 2'h3;
      estop <= 1'b1;
      link <= 4'hA;
      cyc(5);
      check({fl2, fl, el, al}, 7'h1A);
      rdc(`REG_INDICATOR, 32'h54);
      rdc(`REG_STATUS, 32'hAE);
      wr(`REG_MASK, 32'h8);
      cyc(2);
      check(irq, 1'b1);
      wr(`REG_STATUS, 32'hFF);
      rdc(`REG_STATUS, 32'h0);
      check(irq, 1'b0);
      @(posedge clk_sys_i);
      fuse <= 2'h0;
      estop <= 1'b0;
      link <= 4'h0;
      cyc(5);
      check({fl2, fl, el, al}, 7'h60);
      wr(`REG_CTRL, 32'h2);
      cyc(3);
      check(rows_n, 8'hFF);
      wr(`REG_CTRL, 32'h3);
      cyc(3);
      check(rows_n, 8'hFE);
      stop_test();
   end
endmodule
